// [rtl/scp_pkg.sv]
// shared constants and helpers for the six-bit character channel port
package scp_pkg;

   // character, address and unit field widths
   localparam int CHAR_W = 6;
   localparam int ADDR_W = 12;
   localparam int UNIT_W = 5;

   // instruction mode codes presented with each issued instruction
   localparam logic [1:0] MODE_BUFFER   = 2'h0;
   localparam logic [1:0] MODE_INTERNAL = 2'h1;
   localparam logic [1:0] MODE_IO       = 2'h2;
   localparam logic [1:0] MODE_SYSTEM   = 2'h3;

   // unit address field inside the buffer-control address word
   localparam int DIR_POS  = 5;
   localparam int UNIT_LSB = 0;

   // computer cycle timing phases T0..T7
   localparam int         PHASE_W     = 3;
   localparam logic [2:0] PHASE_OPEN  = 3'h6;
   localparam logic [2:0] PHASE_CLOSE = 3'h3;

   // positions inside the synchronised pin vector
   localparam int PIN_CHAR  = 0;
   localparam int PIN_PAR   = 6;
   localparam int PIN_CLK   = 7;
   localparam int PIN_HALT  = 8;
   localparam int PIN_RESP  = 9;
   localparam int PIN_INH   = 10;
   localparam int PIN_ERR   = 11;
   localparam int PIN_W     = 12;

   // reset values; control pins read inactive, character clock idle high, character and parity lines low
   localparam logic [CHAR_W-1:0] CHAR_RST = 6'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
   localparam logic [UNIT_W-1:0] UNIT_RST = 5'h00;
   localparam logic [PIN_W-1:0]  PIN_RST  = 12'hf80;

   // odd parity bit for a character
   function automatic logic odd_parity(input logic [CHAR_W-1:0] c);
      odd_parity = ~(^c);
   endfunction

endpackage

// [rtl/scp_sync.sv]
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module scp_sync #(
   parameter int                  WIDTH = 12,
   parameter logic [WIDTH-1:0]    RST   = '0
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_ff <= RST;
         sync_ff <= RST;
      end
      else
      begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule

// [rtl/scp_fifo2.sv]
// two-entry buffer with valid/ready on both sides
`timescale 1ns/100ps
module scp_fifo2 #(
   parameter int WIDTH = 6
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // fill side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // drain side
   output logic                  out_valid_o,
   output logic      [WIDTH-1:0] out_data_o,
   input  wire logic             out_ready_i
);

   logic [WIDTH-1:0] mem_ff [2];
   logic             wr_ptr_ff;
   logic             rd_ptr_ff;
   logic [1:0]       count_ff;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count_ff != 2'h2);
   assign out_valid_o = (count_ff != 2'h0);
   assign out_data_o  = mem_ff[rd_ptr_ff];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem_ff[wr_ptr_ff] <= in_data_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         count_ff  <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ptr_ff <= ~wr_ptr_ff;
         if (pop)
            rd_ptr_ff <= ~rd_ptr_ff;
         if (push & ~pop)
            count_ff <= count_ff + 2'h1;
         else if (pop & ~push)
            count_ff <= count_ff - 2'h1;
      end
   end

endmodule

// [rtl/scp_port.sv]
// six-bit character channel port: channel side of the peripheral connector
`timescale 1ns/100ps
module scp_port (
   // clock and reset
   input  wire logic                            CLOCK_I,
   input  wire logic                            RESET_I,
   // instruction issue from the computer
   input  wire logic                            INSTR_VALID_I,
   input  wire logic                            INSTR_IS_SKIP_I,
   input  wire logic [1:0]                      INSTR_MODE_I,
   input  wire logic [scp_pkg::ADDR_W-1:0]      INSTR_ADDR_I,
   output logic                                 SKIP_NEXT_O,
   // outgoing characters from the word side
   input  wire logic                            TX_VALID_I,
   input  wire logic [scp_pkg::CHAR_W-1:0]      TX_CHAR_I,
   output logic                                 TX_READY_O,
   // incoming characters to the word side
   output logic                                 RX_VALID_O,
   output logic      [scp_pkg::CHAR_W-1:0]      RX_CHAR_O,
   input  wire logic                            RX_READY_I,
   // status and error flags
   output logic                                 ACTIVE_O,
   output logic                                 PERIPH_ERROR_O,
   output logic                                 PARITY_ERROR_O,
   output logic                                 OVERRUN_ERROR_O,
   input  wire logic                            CLEAR_ERRORS_I,
   // peripheral connector inputs
   input  wire logic [scp_pkg::CHAR_W-1:0]      INPUT_CHAR_LINES_N_I,
   input  wire logic                            INPUT_PARITY_I,
   input  wire logic                            CHAR_CLOCK_I,
   input  wire logic                            HALT_N_I,
   input  wire logic                            SKIP_RESPONSE_N_I,
   input  wire logic                            PARITY_INHIBIT_N_I,
   input  wire logic                            ERROR_N_I,
   // peripheral connector outputs
   output logic                                 BUFFER_CTRL_STROBE_O,
   output logic                                 IO_MODE_STROBE_O,
   output logic                                 HALT_INTERLOCK_O,
   output logic                                 TRANSFER_PENDING_O,
   output logic                                 CLOCK_SEEN_O,
   output logic                                 CYCLE_PHASE_WINDOW_O,
   output logic                                 TRANSFER_DIRECTION_O,
   output logic      [scp_pkg::UNIT_W-1:0]      UNIT_SELECT_LINES_O,
   output logic      [scp_pkg::CHAR_W-1:0]      OUTPUT_CHAR_LINES_O,
   output logic                                 OUTPUT_PARITY_O,
   output logic      [scp_pkg::ADDR_W-1:0]      INSTRUCTION_ADDRESS_LINES_O
);

   typedef enum logic {PROC_IDLE, PROC_RUN} scp_proc_type;

   // synchronised pins
   logic [scp_pkg::PIN_W-1:0]  pins_async;
   logic [scp_pkg::PIN_W-1:0]  pins_sync;
   logic [scp_pkg::CHAR_W-1:0] s_char_n;
   logic                       s_par;
   logic                       s_clk;
   logic                       s_halt_n;
   logic                       s_resp_n;
   logic                       s_inh_n;
   logic                       s_err_n;

   // process state
   scp_proc_type               proc_ff;
   logic                       clk_prev_ff;
   logic                       clock_seen_ff;
   logic                       transfer_pending_ff;
   logic                       halt_interlock_ff;
   logic                       direction_ff;
   logic [scp_pkg::UNIT_W-1:0] unit_ff;
   logic [scp_pkg::CHAR_W-1:0] char_ff;
   logic                       out_par_ff;
   logic [scp_pkg::ADDR_W-1:0] addr_ff;
   logic [scp_pkg::PHASE_W-1:0] phase_ff;
   logic                       phase_win_ff;
   logic                       buc_ff;
   logic                       ioc_ff;
   logic                       skip_ff;
   logic                       periph_err_ff;
   logic                       parity_err_ff;
   logic                       overrun_ff;

   // decoded events
   logic                       running;
   logic                       clk_rise;
   logic                       accept;
   logic                       overrun_evt;
   logic                       halt_req;
   logic                       start;
   logic                       energize_output_instr;
   logic                       in_char_parity_bad;
   logic [scp_pkg::CHAR_W-1:0] in_char;
   logic                       move_in;
   logic                       move_out;

   // buffer wiring
   logic                       rx_in_ready;
   logic                       tx_out_valid;
   logic [scp_pkg::CHAR_W-1:0] tx_out_data;

   // all pin levels enter through one synchroniser
   assign pins_async = {ERROR_N_I,
                        PARITY_INHIBIT_N_I,
                        SKIP_RESPONSE_N_I,
                        HALT_N_I,
                        CHAR_CLOCK_I,
                        INPUT_PARITY_I,
                        INPUT_CHAR_LINES_N_I};

   scp_sync #(
      .WIDTH (scp_pkg::PIN_W),
      .RST   (scp_pkg::PIN_RST)
   ) u_sync (
      .clk_i   (CLOCK_I),
      .rst_i   (RESET_I),
      .async_i (pins_async),
      .sync_o  (pins_sync)
   );

   assign s_char_n = pins_sync[scp_pkg::PIN_CHAR +: scp_pkg::CHAR_W];
   assign s_par    = pins_sync[scp_pkg::PIN_PAR];
   assign s_clk    = pins_sync[scp_pkg::PIN_CLK];
   assign s_halt_n = pins_sync[scp_pkg::PIN_HALT];
   assign s_resp_n = pins_sync[scp_pkg::PIN_RESP];
   assign s_inh_n  = pins_sync[scp_pkg::PIN_INH];
   assign s_err_n  = pins_sync[scp_pkg::PIN_ERR];

   // ground-true lines; bit 0 is the sixth line
   assign in_char = ~s_char_n;

   // instruction decode
   assign energize_output_instr   = INSTR_VALID_I & ~INSTR_IS_SKIP_I;
   assign start = energize_output_instr & (INSTR_MODE_I == scp_pkg::MODE_BUFFER);

   // character clock edge and process events
   assign running     = (proc_ff == PROC_RUN);
   assign clk_rise    = s_clk & ~clk_prev_ff;
   assign accept      = clk_rise & running & ~clock_seen_ff & ~transfer_pending_ff;
   assign overrun_evt = clk_rise & running & (clock_seen_ff | transfer_pending_ff);
   assign halt_req    = ~s_halt_n & running;
   assign in_char_parity_bad = (s_par != scp_pkg::odd_parity(in_char));

   // moves between character register and the word-side buffers
   assign move_in  = transfer_pending_ff & ~direction_ff & rx_in_ready;
   assign move_out = transfer_pending_ff & direction_ff & running & tx_out_valid;

   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         clk_prev_ff <= scp_pkg::PIN_RST[scp_pkg::PIN_CLK];
      else
         clk_prev_ff <= s_clk;
   end

   // process run state: started by buffer control, ended by halt
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         proc_ff <= PROC_IDLE;
      else
      begin
         unique case (proc_ff)
            PROC_IDLE:
               if (start)
                  proc_ff <= PROC_RUN;
            PROC_RUN:
               if (start)
                  proc_ff <= PROC_RUN;
               else if (halt_req)
                  proc_ff <= PROC_IDLE;
         endcase
      end
   end

   // unit address register
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         direction_ff <= 1'b0;
         unit_ff      <= scp_pkg::UNIT_RST;
      end
      else if (start)
      begin
         direction_ff <= INSTR_ADDR_I[scp_pkg::DIR_POS];
         unit_ff      <= INSTR_ADDR_I[scp_pkg::UNIT_LSB +: scp_pkg::UNIT_W];
      end
   end

   // clock seen: one cycle per accepted clock, then hands over to pending
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         clock_seen_ff <= 1'b0;
      else if (start)
         clock_seen_ff <= 1'b0;
      else if (accept)
         clock_seen_ff <= 1'b1;
      else
         clock_seen_ff <= 1'b0;
   end

   // transfer pending: output starts needing a character
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         transfer_pending_ff <= 1'b0;
      else if (start)
         transfer_pending_ff <= INSTR_ADDR_I[scp_pkg::DIR_POS];
      else if (clock_seen_ff)
         transfer_pending_ff <= 1'b1;
      else if (move_in | move_out)
         transfer_pending_ff <= 1'b0;
   end

   // halt interlock
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         halt_interlock_ff <= 1'b0;
      else if (start)
         halt_interlock_ff <= 1'b0;
      else if (accept & ~direction_ff)
         halt_interlock_ff <= 1'b1;
      else if (halt_req & direction_ff)
         halt_interlock_ff <= 1'b1;
   end

   // character register and its parity
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         char_ff    <= scp_pkg::CHAR_RST;
         out_par_ff <= scp_pkg::odd_parity(scp_pkg::CHAR_RST);
      end
      else if (accept & ~direction_ff)
      begin
         char_ff    <= in_char;
         out_par_ff <= scp_pkg::odd_parity(in_char);
      end
      else if (move_out)
      begin
         char_ff    <= tx_out_data;
         out_par_ff <= scp_pkg::odd_parity(tx_out_data);
      end
   end

   // sticky errors; a new event wins over the clear
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         periph_err_ff <= 1'b0;
      else if (~s_err_n)
         periph_err_ff <= 1'b1;
      else if (CLEAR_ERRORS_I)
         periph_err_ff <= 1'b0;
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         parity_err_ff <= 1'b0;
      else if (accept & ~direction_ff & s_inh_n & in_char_parity_bad)
         parity_err_ff <= 1'b1;
      else if (CLEAR_ERRORS_I)
         parity_err_ff <= 1'b0;
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         overrun_ff <= 1'b0;
      else if (overrun_evt)
         overrun_ff <= 1'b1;
      else if (CLEAR_ERRORS_I)
         overrun_ff <= 1'b0;
   end

   // instruction strobes, address lines and skip answer
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         buc_ff  <= 1'b0;
         ioc_ff  <= 1'b0;
         skip_ff <= 1'b0;
      end
      else
      begin
         buc_ff  <= start;
         ioc_ff  <= energize_output_instr & (INSTR_MODE_I == scp_pkg::MODE_IO);
         skip_ff <= INSTR_VALID_I & INSTR_IS_SKIP_I & ~s_resp_n;
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         addr_ff <= scp_pkg::ADDR_RST;
      else if (INSTR_VALID_I)
         addr_ff <= INSTR_ADDR_I;
   end

   // computer cycle phase counter and T6..T3 window
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         phase_ff     <= '0;
         phase_win_ff <= 1'b0;
      end
      else
      begin
         phase_ff     <= phase_ff + 3'h1;
         phase_win_ff <= ((phase_ff + 3'h1) >= scp_pkg::PHASE_OPEN) ||
                         ((phase_ff + 3'h1) <= scp_pkg::PHASE_CLOSE);
      end
   end

   // received characters wait here when the word side stalls
   scp_fifo2 #(
      .WIDTH (scp_pkg::CHAR_W)
   ) u_rx_buf (
      .clk_i       (CLOCK_I),
      .rst_i       (RESET_I),
      .in_valid_i  (transfer_pending_ff & ~direction_ff),
      .in_data_i   (char_ff),
      .in_ready_o  (rx_in_ready),
      .out_valid_o (RX_VALID_O),
      .out_data_o  (RX_CHAR_O),
      .out_ready_i (RX_READY_I)
   );

   // characters to send wait here until the peripheral asks
   scp_fifo2 #(
      .WIDTH (scp_pkg::CHAR_W)
   ) u_tx_buf (
      .clk_i       (CLOCK_I),
      .rst_i       (RESET_I),
      .in_valid_i  (TX_VALID_I),
      .in_data_i   (TX_CHAR_I),
      .in_ready_o  (TX_READY_O),
      .out_valid_o (tx_out_valid),
      .out_data_o  (tx_out_data),
      .out_ready_i (transfer_pending_ff & direction_ff & running)
   );

   // outputs
   assign SKIP_NEXT_O                 = skip_ff;
   assign ACTIVE_O                    = running;
   assign PERIPH_ERROR_O              = periph_err_ff;
   assign PARITY_ERROR_O              = parity_err_ff;
   assign OVERRUN_ERROR_O             = overrun_ff;
   assign BUFFER_CTRL_STROBE_O        = buc_ff;
   assign IO_MODE_STROBE_O            = ioc_ff;
   assign HALT_INTERLOCK_O            = halt_interlock_ff;
   assign TRANSFER_PENDING_O          = transfer_pending_ff;
   assign CLOCK_SEEN_O                = clock_seen_ff;
   assign CYCLE_PHASE_WINDOW_O        = phase_win_ff;
   assign TRANSFER_DIRECTION_O        = direction_ff;
   assign UNIT_SELECT_LINES_O         = unit_ff;
   assign OUTPUT_CHAR_LINES_O         = char_ff;
   assign OUTPUT_PARITY_O             = out_par_ff;
   assign INSTRUCTION_ADDRESS_LINES_O = addr_ff;

endmodule

// [bench/scp_port_chk.sv]
// assertion checker for the six-bit character channel port
`timescale 1ns/100ps
module scp_port_chk (
   // clock and reset
   input wire logic        CLOCK_I,
   input wire logic        RESET_I,
   // instruction issue
   input wire logic        INSTR_VALID_I,
   input wire logic        INSTR_IS_SKIP_I,
   input wire logic [1:0]  INSTR_MODE_I,
   input wire logic [11:0] INSTR_ADDR_I,
   input wire logic        SKIP_NEXT_O,
   // peripheral side
   input wire logic        ERROR_N_I,
   input wire logic        PERIPH_ERROR_O,
   input wire logic        BUFFER_CTRL_STROBE_O,
   input wire logic        IO_MODE_STROBE_O,
   input wire logic        TRANSFER_PENDING_O,
   input wire logic        CLOCK_SEEN_O,
   input wire logic        CYCLE_PHASE_WINDOW_O,
   input wire logic        TRANSFER_DIRECTION_O,
   input wire logic [4:0]  UNIT_SELECT_LINES_O,
   input wire logic [5:0]  OUTPUT_CHAR_LINES_O,
   input wire logic        OUTPUT_PARITY_O,
   input wire logic [11:0] INSTRUCTION_ADDRESS_LINES_O
);
   logic eom_b;
   logic eom_io;
   assign eom_b  = INSTR_VALID_I && !INSTR_IS_SKIP_I && INSTR_MODE_I == scp_pkg::MODE_BUFFER;
   assign eom_io = INSTR_VALID_I && !INSTR_IS_SKIP_I && INSTR_MODE_I == scp_pkg::MODE_IO;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);
   AST_BUC_STROBE: assert property (BUFFER_CTRL_STROBE_O == $past(eom_b))
      else $error("buffer strobe mismatch");
   AST_IO_STROBE: assert property (IO_MODE_STROBE_O == $past(eom_io))
      else $error("io strobe mismatch");
   AST_ADDR_LINES: assert property (INSTR_VALID_I |=>
      INSTRUCTION_ADDRESS_LINES_O == $past(INSTR_ADDR_I)) else $error("address lines wrong");
   AST_UNIT_LOAD: assert property (eom_b |=>
      {TRANSFER_DIRECTION_O, UNIT_SELECT_LINES_O} == $past(INSTR_ADDR_I[5:0]))
      else $error("unit register wrong");
   AST_UNIT_HOLD: assert property (!eom_b |=>
      $stable({TRANSFER_DIRECTION_O, UNIT_SELECT_LINES_O})) else $error("unit register moved");
   AST_OUT_PARITY: assert property (OUTPUT_PARITY_O == ~(^OUTPUT_CHAR_LINES_O))
      else $error("output parity wrong");
   AST_SEEN_PULSE: assert property ($rose(CLOCK_SEEN_O) |=>
      !CLOCK_SEEN_O && TRANSFER_PENDING_O) else $error("clock seen sequence wrong");
   AST_SKIP_CAUSE: assert property (SKIP_NEXT_O |-> $past(INSTR_VALID_I && INSTR_IS_SKIP_I))
      else $error("skip without test");
   AST_WINDOW: assert property ($fell(CYCLE_PHASE_WINDOW_O) |=> !CYCLE_PHASE_WINDOW_O
      ##1 CYCLE_PHASE_WINDOW_O [*6] ##1 !CYCLE_PHASE_WINDOW_O) else $error("window shape wrong");
   AST_PERIPH_ERR: assert property ($fell(ERROR_N_I) ##1 !ERROR_N_I [*3] |=>
      PERIPH_ERROR_O) else $error("error not registered");
   cover property ($rose(CLOCK_SEEN_O) && !TRANSFER_DIRECTION_O);
   cover property ($rose(CLOCK_SEEN_O) && TRANSFER_DIRECTION_O);
   cover property (SKIP_NEXT_O);
   cover property (BUFFER_CTRL_STROBE_O);
endmodule

bind scp_port scp_port_chk u_scp_port_chk (
   .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .INSTR_VALID_I(INSTR_VALID_I),
   .INSTR_IS_SKIP_I(INSTR_IS_SKIP_I), .INSTR_MODE_I(INSTR_MODE_I), .INSTR_ADDR_I(INSTR_ADDR_I),
   .SKIP_NEXT_O(SKIP_NEXT_O), .ERROR_N_I(ERROR_N_I), .PERIPH_ERROR_O(PERIPH_ERROR_O),
   .BUFFER_CTRL_STROBE_O(BUFFER_CTRL_STROBE_O), .IO_MODE_STROBE_O(IO_MODE_STROBE_O),
   .TRANSFER_PENDING_O(TRANSFER_PENDING_O), .CLOCK_SEEN_O(CLOCK_SEEN_O),
   .CYCLE_PHASE_WINDOW_O(CYCLE_PHASE_WINDOW_O), .TRANSFER_DIRECTION_O(TRANSFER_DIRECTION_O),
   .UNIT_SELECT_LINES_O(UNIT_SELECT_LINES_O), .OUTPUT_CHAR_LINES_O(OUTPUT_CHAR_LINES_O),
   .OUTPUT_PARITY_O(OUTPUT_PARITY_O), .INSTRUCTION_ADDRESS_LINES_O(INSTRUCTION_ADDRESS_LINES_O));

// [bench/scp_peri.sv]
// behavioural peripheral unit driving the character link
`timescale 1ns/100ps
module scp_peri (
   // flags from the channel
   input  wire logic       seen_i,
   input  wire logic       pend_i,
   input  wire logic       bad_i,
   // connector lines
   output logic      [5:0] lines_n_o,
   output logic            par_o,
   output logic            ck_o
);
   logic [5:0] d;
   initial
   begin
      d = 6'h2a;
      ck_o = 1'b1;
      lines_n_o = 6'h3f;
      par_o = 1'b0;
   end
   // n character clocks, clock idle high outside the frame
   task automatic clocks(input int n);
      int w;
      repeat (n)
      begin
         w = 0;
         while ((seen_i || pend_i) && w < 200)
         begin
            #20 w++;
         end
         #7.3 ck_o = 1'b0;
         lines_n_o = ~d;
         par_o = ~(^d) ^ bad_i;
         #80 ck_o = 1'b1;
         #80 d = d + 6'h01;
      end
      lines_n_o = ~lines_n_o;
   endtask
endmodule

// [bench/scp_port_tb.sv]
// self-checking bench for the six-bit character channel port
`timescale 1ns/100ps
module scp_port_tb;
   logic        clk, rst, iv, isk, tx_v, rx_rdy, clr, halt_n, resp_n, inh_n, err_n, bad;
   logic        skip, tx_rdy, rxv, act, perr, parerr, buc, io_mode_strobe, hint, pend, seen, win, dir;
   logic        par, ipar, ck, ovr;
   logic [1:0]  im;
   logic [4:0]  unit;
   logic [5:0]  tx_c, rx_c, out_c, lin;
   logic [11:0] ia, addr_o;
   int          err_total, n_tests;
   scp_port u_scp_port (.CLOCK_I(clk), .RESET_I(rst), .INSTR_VALID_I(iv), .INSTR_IS_SKIP_I(isk),
      .INSTR_MODE_I(im), .INSTR_ADDR_I(ia), .SKIP_NEXT_O(skip), .TX_VALID_I(tx_v),
      .TX_CHAR_I(tx_c), .TX_READY_O(tx_rdy), .RX_VALID_O(rxv), .RX_CHAR_O(rx_c),
      .RX_READY_I(rx_rdy), .ACTIVE_O(act), .PERIPH_ERROR_O(perr), .PARITY_ERROR_O(parerr),
      .OVERRUN_ERROR_O(ovr), .CLEAR_ERRORS_I(clr), .INPUT_CHAR_LINES_N_I(lin),
      .INPUT_PARITY_I(ipar), .CHAR_CLOCK_I(ck), .HALT_N_I(halt_n), .SKIP_RESPONSE_N_I(resp_n),
      .PARITY_INHIBIT_N_I(inh_n), .ERROR_N_I(err_n), .BUFFER_CTRL_STROBE_O(buc),
      .IO_MODE_STROBE_O(io_mode_strobe), .HALT_INTERLOCK_O(hint), .TRANSFER_PENDING_O(pend),
      .CLOCK_SEEN_O(seen), .CYCLE_PHASE_WINDOW_O(win), .TRANSFER_DIRECTION_O(dir),
      .UNIT_SELECT_LINES_O(unit), .OUTPUT_CHAR_LINES_O(out_c), .OUTPUT_PARITY_O(par),
      .INSTRUCTION_ADDRESS_LINES_O(addr_o));
   scp_peri u_scp_peri (.seen_i(seen), .pend_i(pend), .bad_i(bad), .lines_n_o(lin),
      .par_o(ipar), .ck_o(ck));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task chk(input logic [11:0] g, input logic [11:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task issue(input logic s, input logic [1:0] m, input logic [11:0] a);
      @(posedge clk);
      iv <= 1'b1;
      isk <= s;
      im <= m;
      ia <= a;
      @(posedge clk);
      iv <= 1'b0;
      @(negedge clk);
   endtask
   task rx1(input logic [5:0] e);
      int i;
      i = 0;
      @(negedge clk);
      while (rxv !== 1'b1 && i < 100)
      begin
         @(negedge clk);
         i++;
      end
      chk(rx_c, e);
      @(posedge clk);
   endtask
   task tx1(input logic [5:0] c);
      int i;
      i = 0;
      @(posedge clk);
      tx_v <= 1'b1;
      tx_c <= c;
      @(negedge clk);
      while (tx_rdy !== 1'b1 && i < 100)
      begin
         @(negedge clk);
         i++;
      end
      @(posedge clk);
      tx_v <= 1'b0;
   endtask
   // halt, then expect idle with the given interlock, seen and pending flags
   task stop(input logic [2:0] e);
      @(posedge clk);
      halt_n <= 1'b0;
      repeat (6) @(negedge clk);
      chk({act, hint, seen, pend}, {1'b0, e});
      @(posedge clk);
      halt_n <= 1'b1;
   endtask
   task t_reset;
      @(negedge clk);
      chk({tx_rdy, par, buc, io_mode_strobe, act, pend, seen, hint, skip, ovr}, 10'h300);
      $display("reset test done");
   endtask
   task t_window;
      int n;
      n = 0;
      repeat (16)
      begin
         @(negedge clk);
         n += win;
      end
      chk(n, 12);
      $display("window test done");
   endtask
   task t_instr;
      for (int m = 0; m < 4; m++)
      begin
         issue(1'b0, m, 12'h2b4 | m);
         chk({buc, io_mode_strobe}, {m == 0, m == 2});
         chk(addr_o, 12'h2b4 | m);
      end
      chk({dir, unit}, 6'h34);
      stop(3'h5);
      resp_n <= 1'b0;
      repeat (4) @(posedge clk);
      issue(1'b1, scp_pkg::MODE_IO, 12'h7f1);
      chk(skip, 1);
      @(posedge clk);
      resp_n <= 1'b1;
      repeat (4) @(posedge clk);
      issue(1'b1, scp_pkg::MODE_IO, 12'h7f1);
      chk(skip, 0);
      $display("instruction test done");
   endtask
   task t_input;
      issue(1'b0, scp_pkg::MODE_BUFFER, 12'h005);
      chk({act, dir, unit}, 7'h45);
      fork
         u_scp_peri.clocks(4);
         begin
            repeat (120) @(posedge clk);
            chk({rxv, pend, hint}, 3'h7);
            rx_rdy <= 1'b1;
            for (int k = 0; k < 4; k++)
               rx1(6'h2a + k);
         end
      join
      bad <= 1'b1;
      inh_n <= 1'b0;
      u_scp_peri.clocks(1);
      rx1(6'h2e);
      chk(parerr, 0);
      inh_n <= 1'b1;
      u_scp_peri.clocks(1);
      rx1(6'h2f);
      chk(parerr, 1);
      bad <= 1'b0;
      stop(3'h4);
      rx_rdy <= 1'b0;
      u_scp_peri.clocks(1);
      repeat (8) @(negedge clk);
      chk(rxv, 0);
      $display("input test done");
   endtask
   task t_output;
      issue(1'b0, scp_pkg::MODE_BUFFER, 12'h029);
      chk({act, dir, unit}, 7'h69);
      tx1(6'h01);
      repeat (3) @(negedge clk);
      chk({par, out_c}, 7'h01);
      tx1(6'h3e);
      tx1(6'h2b);
      @(negedge clk);
      chk(tx_rdy, 0);
      u_scp_peri.clocks(1);
      repeat (4) @(negedge clk);
      chk({par, out_c}, 7'h3e);
      u_scp_peri.clocks(1);
      repeat (4) @(negedge clk);
      chk({ovr, par, out_c}, 8'h6b);
      // second clock ignores the pending flag after its wait runs out
      u_scp_peri.clocks(2);
      repeat (4) @(negedge clk);
      chk(ovr, 1);
      stop(3'h5);
      $display("output test done");
   endtask
   task t_error;
      @(posedge clk);
      err_n <= 1'b0;
      repeat (5) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      err_n <= 1'b1;
      @(negedge clk);
      chk({perr, parerr, ovr}, 3'h4);
      repeat (4) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (2) @(negedge clk);
      chk({perr, parerr, ovr}, 0);
      $display("error test done");
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      err_total++;
      give_verdict;
   end
   initial
   begin
      {iv, isk, im, ia, tx_v, tx_c, rx_rdy, clr, bad} = '0;
      {rst, halt_n, resp_n, inh_n, err_n} = '1;
      err_total = 0;
      n_tests = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_window;
      t_instr;
      t_input;
      t_output;
      t_error;
      give_verdict;
   end
endmodule
